// ===== core/rtcosc_top.sv
// apb register core of the timebase oscillator configuration block
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "rtcosc_map.svh"
module rtcosc_top #(
    parameter int BLANK_CYCLES = (`RTCOSC_BLANK_TIME_NS
        + `RTCOSC_CLK_PERIOD_NS - 1) / `RTCOSC_CLK_PERIOD_NS,
    parameter int MISS_CYCLES = (`RTCOSC_MISS_TIME_NS
        + `RTCOSC_CLK_PERIOD_NS - 1) / `RTCOSC_CLK_PERIOD_NS
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic osc_pin_a,
    input wire logic slow_internal_osc,
    input wire logic amp_detect,
    output logic osc_power_en,
    output logic osc_mode_select,
    output logic bias_double_en,
    output logic gain_control,
    output logic slow_osc_enable,
    output logic pin_short_ctrl,
    output logic [3:0] load_cap_code,
    output logic [1:0] timer_inc
);
    localparam logic [17:0] BLANK_LAST = 18'(BLANK_CYCLES);
    localparam logic [17:0] MISS_LAST = 18'(MISS_CYCLES);
    // reset words held as typed constants so single fields can be picked
    localparam logic [7:0] OSC_CTRL_RST = `RTCOSC_OSC_CTRL_RST;
    localparam logic [7:0] CAP_CFG_RST = `RTCOSC_CAP_CFG_RST;
    localparam logic [1:0] PWR_CTRL_RST = `RTCOSC_PWR_CTRL_RST;

    // ======================================================================
    // control state
    logic mode_ff;
    logic bias_ff;
    logic gain_en_ff;
    logic slow_ff;
    logic short_ff;
    logic auto_ff;
    rtcosc_pkg::rtcosc_cap_code_t code_ff;
    logic pwr_ff;
    logic mcd_ff;
    logic [2:0] stat_ff;
    logic [2:0] mask_ff;
    logic [2:0] nxt_stat;
    logic gain_out_ff;
    logic [31:0] rdata_ff;
    logic tb_ff;
    logic tb_prev_ff;
    logic [1:0] inc_ff;
    logic [17:0] blank_cnt_ff;
    logic [17:0] miss_cnt_ff;
    logic ready_prev_ff;
    logic blank_prev_ff;
    logic wr_en;
    logic rd_setup;
    logic tb_rise;
    logic tb_edge;
    logic blank_done;
    logic clk_valid;
    logic fail_ev;
    logic [2:0] set_ev;
    logic [2:0] clr_ev;

    rtcosc_cap_if cap_bus ();

    // ======================================================================
    // apb access decode; zero wait states, so pready is simply high
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_mapped(paddr);
    assign prdata = rdata_ff;

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == `RTCOSC_OSC_CTRL_OFS) ||
                      (a == `RTCOSC_CAP_CFG_OFS) ||
                      (a == `RTCOSC_PIN_SHORT_OFS) ||
                      (a == `RTCOSC_PWR_CTRL_OFS) ||
                      (a == `RTCOSC_IRQ_STAT_OFS) ||
                      (a == `RTCOSC_IRQ_MASK_OFS) ||
                      (a == `RTCOSC_LIVE_OFS);
    endfunction : addr_mapped

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = wr_en && (paddr == a);
    endfunction : wr_hit

    // ======================================================================
    // oscillator control register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            gain_en_ff <= OSC_CTRL_RST[`RTCOSC_GAIN_BIT];
            mode_ff <= OSC_CTRL_RST[`RTCOSC_MODE_BIT];
            bias_ff <= OSC_CTRL_RST[`RTCOSC_BIAS_BIT];
            slow_ff <= OSC_CTRL_RST[`RTCOSC_SLOW_BIT];
        end else if (wr_hit(`RTCOSC_OSC_CTRL_OFS)) begin
            gain_en_ff <= pwdata[`RTCOSC_GAIN_BIT];
            mode_ff <= pwdata[`RTCOSC_MODE_BIT];
            bias_ff <= pwdata[`RTCOSC_BIAS_BIT];
            slow_ff <= pwdata[`RTCOSC_SLOW_BIT];
        end
    end

    // gain control only reaches the core in crystal mode
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            gain_out_ff <= 1'b0;
        end else begin
            gain_out_ff <= gain_en_ff && mode_ff;
        end
    end

    // ======================================================================
    // capacitance config, pin short and power / detector control
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            auto_ff <= CAP_CFG_RST[`RTCOSC_AUTO_BIT];
            code_ff <= CAP_CFG_RST[`RTCOSC_CODE_MSB:0];
        end else if (wr_hit(`RTCOSC_CAP_CFG_OFS)) begin
            auto_ff <= pwdata[`RTCOSC_AUTO_BIT];
            code_ff <= pwdata[`RTCOSC_CODE_MSB:0];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            short_ff <= `RTCOSC_PIN_SHORT_RST;
        end else if (wr_hit(`RTCOSC_PIN_SHORT_OFS)) begin
            short_ff <= pwdata[`RTCOSC_SHORT_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pwr_ff <= PWR_CTRL_RST[`RTCOSC_PWR_BIT];
            mcd_ff <= PWR_CTRL_RST[`RTCOSC_MCD_BIT];
        end else if (wr_hit(`RTCOSC_PWR_CTRL_OFS)) begin
            pwr_ff <= pwdata[`RTCOSC_PWR_BIT];
            mcd_ff <= pwdata[`RTCOSC_MCD_BIT];
        end
    end

    // ======================================================================
    // timebase sampling; the slow oscillator replaces the pin when selected
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tb_ff <= 1'b0;
            tb_prev_ff <= 1'b0;
        end else begin
            tb_ff <= slow_ff ? slow_internal_osc : osc_pin_a;
            tb_prev_ff <= tb_ff;
        end
    end
    assign tb_rise = tb_ff && !tb_prev_ff;
    assign tb_edge = tb_ff ^ tb_prev_ff;

    // timer increment: bit 1 instead of bit 0 on the slow oscillator
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            inc_ff <= 2'b00;
        end else if (tb_rise) begin
            inc_ff <= slow_ff ? 2'b10 : 2'b01;
        end else begin
            inc_ff <= 2'b00;
        end
    end

    // ======================================================================
    // blanking after power on; self-oscillate and slow modes skip it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            blank_cnt_ff <= 18'h0_0000;
        end else if (!pwr_ff) begin
            blank_cnt_ff <= 18'h0_0000;
        end else if (blank_cnt_ff != BLANK_LAST) begin
            blank_cnt_ff <= blank_cnt_ff + 18'h0_0001;
        end
    end
    assign blank_done = pwr_ff && (blank_cnt_ff == BLANK_LAST);
    // detector output is masked while blanking in crystal mode
    assign clk_valid = amp_detect && pwr_ff &&
                       (blank_done || !mode_ff || slow_ff);

    // ======================================================================
    // missing clock one-shot: fires once per stuck level, rearmed by an edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            miss_cnt_ff <= 18'h0_0000;
        end else if (!mcd_ff || tb_edge) begin
            miss_cnt_ff <= 18'h0_0000;
        end else if (miss_cnt_ff <= MISS_LAST) begin
            miss_cnt_ff <= miss_cnt_ff + 18'h0_0001;
        end
    end
    assign fail_ev = mcd_ff && !tb_edge && (miss_cnt_ff == MISS_LAST);

    // ======================================================================
    // capacitance stepper, restarted by config writes and by power on
    assign cap_bus.restart = wr_hit(`RTCOSC_CAP_CFG_OFS) ||
                             (wr_hit(`RTCOSC_PWR_CTRL_OFS) &&
                              pwdata[`RTCOSC_PWR_BIT] && !pwr_ff);
    assign cap_bus.tick = tb_rise;
    assign cap_bus.auto_en = auto_ff;
    assign cap_bus.target = code_ff;

    rtcosc_cap_stepper u_stepper (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .bus(cap_bus.step)
    );

    // ======================================================================
    // sticky events, write one to clear; a new event beats the clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ready_prev_ff <= 1'b0;
            blank_prev_ff <= 1'b0;
        end else begin
            ready_prev_ff <= cap_bus.ready;
            blank_prev_ff <= blank_done;
        end
    end

    always_comb begin
        set_ev = 3'b000;
        set_ev[`RTCOSC_EV_FAIL] = fail_ev;
        set_ev[`RTCOSC_EV_READY] = cap_bus.ready && !ready_prev_ff;
        set_ev[`RTCOSC_EV_BLANK] = blank_done && !blank_prev_ff;
        clr_ev = wr_hit(`RTCOSC_IRQ_STAT_OFS) ? pwdata[2:0] : 3'b000;
        nxt_stat = (stat_ff & ~clr_ev) | set_ev;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stat_ff <= `RTCOSC_EV_RST;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mask_ff <= `RTCOSC_EV_RST;
        end else if (wr_hit(`RTCOSC_IRQ_MASK_OFS)) begin
            mask_ff <= pwdata[2:0];
        end
    end

    assign irq = |(stat_ff & mask_ff);

    // ======================================================================
    // read data, captured in the setup phase for the access phase
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_setup) begin
            rdata_ff <= 32'h0000_0000;
            case (paddr)
                `RTCOSC_OSC_CTRL_OFS: begin
                    rdata_ff[`RTCOSC_GAIN_BIT] <= gain_en_ff;
                    rdata_ff[`RTCOSC_MODE_BIT] <= mode_ff;
                    rdata_ff[`RTCOSC_BIAS_BIT] <= bias_ff;
                    rdata_ff[`RTCOSC_CLKVALID_BIT] <= clk_valid;
                    rdata_ff[`RTCOSC_SLOW_BIT] <= slow_ff;
                end
                `RTCOSC_CAP_CFG_OFS: begin
                    rdata_ff[`RTCOSC_AUTO_BIT] <= auto_ff;
                    rdata_ff[`RTCOSC_READY_BIT] <= cap_bus.ready;
                    rdata_ff[`RTCOSC_CODE_MSB:0] <= code_ff;
                end
                `RTCOSC_PIN_SHORT_OFS: begin
                    rdata_ff[`RTCOSC_SHORT_BIT] <= short_ff;
                end
                `RTCOSC_PWR_CTRL_OFS: begin
                    rdata_ff[`RTCOSC_PWR_BIT] <= pwr_ff;
                    rdata_ff[`RTCOSC_MCD_BIT] <= mcd_ff;
                end
                `RTCOSC_IRQ_STAT_OFS: begin
                    rdata_ff[2:0] <= stat_ff;
                end
                `RTCOSC_IRQ_MASK_OFS: begin
                    rdata_ff[2:0] <= mask_ff;
                end
                `RTCOSC_LIVE_OFS: begin
                    rdata_ff[`RTCOSC_EV_FAIL] <= stat_ff[`RTCOSC_EV_FAIL];
                    rdata_ff[`RTCOSC_EV_READY] <= cap_bus.ready;
                    rdata_ff[`RTCOSC_EV_BLANK] <= blank_done;
                    rdata_ff[`RTCOSC_EV_W] <= clk_valid;
                end
                default: begin
                    rdata_ff <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ======================================================================
    // outputs to the analog core
    assign osc_power_en = pwr_ff;
    assign osc_mode_select = mode_ff;
    assign bias_double_en = bias_ff;
    assign gain_control = gain_out_ff;
    assign slow_osc_enable = slow_ff;
    assign pin_short_ctrl = short_ff;
    assign load_cap_code = cap_bus.applied;
    assign timer_inc = inc_ff;

    // ======================================================================
    // checks
    short_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_hit(`RTCOSC_PIN_SHORT_OFS) |=> pin_short_ctrl == $past(pwdata[0]))
        else $error("pin short control did not follow write");
    self_osc_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (wr_hit(`RTCOSC_OSC_CTRL_OFS) && !pwdata[`RTCOSC_MODE_BIT])
        |=> !osc_mode_select ##1 !gain_control)
        else $error("mode 0 write left crystal mode or gain on");
    crystal_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (wr_hit(`RTCOSC_OSC_CTRL_OFS) && pwdata[`RTCOSC_MODE_BIT])
        |=> osc_mode_select)
        else $error("mode 1 write did not select crystal");
    bias_bit5_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_hit(`RTCOSC_OSC_CTRL_OFS) |=> bias_double_en == $past(pwdata[5]))
        else $error("bias double not taken from bit 5");
    slow_step_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (tb_rise && slow_ff) |=> timer_inc == 2'b10 ##1 timer_inc != 2'b10
        || $past(tb_rise))
        else $error("slow timebase did not add two");
    blank_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (mode_ff && !slow_ff && !blank_done) |-> !clk_valid)
        else $error("clock valid seen during blanking");
    miss_fail_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (mcd_ff && !tb_edge && miss_cnt_ff == MISS_LAST)
        |=> stat_ff[`RTCOSC_EV_FAIL])
        else $error("stuck timebase did not set fail flag");
    no_early_fail_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!$past(stat_ff[0]) && stat_ff[0]) |-> $past(miss_cnt_ff) == MISS_LAST)
        else $error("fail flag set before level timeout");
    set_wins_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (fail_ev && clr_ev[`RTCOSC_EV_FAIL]) |=> stat_ff[`RTCOSC_EV_FAIL])
        else $error("clear beat a same cycle fail event");
    irq_level_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (stat_ff & mask_ff) != 3'b000 |-> irq ##1 (irq
        || $past(clr_ev) != 3'b000 || $changed(mask_ff)))
        else $error("interrupt not held for unmasked status");

endmodule : rtcosc_top

// ===== core/rtcosc_map.svh
// offsets, field positions, reset values and timing counts of the osc block
`ifndef RTCOSC_MAP_SVH
`define RTCOSC_MAP_SVH

// ==========================================================================
// register byte offsets
`define RTCOSC_OSC_CTRL_OFS 8'h00
`define RTCOSC_CAP_CFG_OFS 8'h04
`define RTCOSC_PIN_SHORT_OFS 8'h08
`define RTCOSC_PWR_CTRL_OFS 8'h0C
`define RTCOSC_IRQ_STAT_OFS 8'h10
`define RTCOSC_IRQ_MASK_OFS 8'h14
`define RTCOSC_LIVE_OFS 8'h18

// ==========================================================================
// osc_ctrl_reg fields
`define RTCOSC_GAIN_BIT 7
`define RTCOSC_MODE_BIT 6
`define RTCOSC_BIAS_BIT 5
`define RTCOSC_CLKVALID_BIT 4
`define RTCOSC_SLOW_BIT 3
// load_cap_config_reg fields
`define RTCOSC_AUTO_BIT 7
`define RTCOSC_READY_BIT 6
`define RTCOSC_CODE_MSB 3
// pin short and power control fields
`define RTCOSC_SHORT_BIT 0
`define RTCOSC_PWR_BIT 0
`define RTCOSC_MCD_BIT 1
// interrupt status / mask and live status fields
`define RTCOSC_EV_FAIL 0
`define RTCOSC_EV_READY 1
`define RTCOSC_EV_BLANK 2
`define RTCOSC_EV_W 3

// ==========================================================================
// reset values
`define RTCOSC_OSC_CTRL_RST 8'h00
`define RTCOSC_CAP_CFG_RST 8'h80
`define RTCOSC_PIN_SHORT_RST 1'b0
`define RTCOSC_PWR_CTRL_RST 2'b00
`define RTCOSC_EV_RST 3'b000

// ==========================================================================
// timing
`define RTCOSC_CLK_PERIOD_NS 8
`define RTCOSC_BLANK_TIME_NS 2000000
`define RTCOSC_MISS_TIME_NS 100000
`define RTCOSC_STEP_OSC_CYCLES 4'hF

`endif

// ===== core/rtcosc_pkg.sv
// types shared by the osc configuration block
package rtcosc_pkg;

    // ======================================================================
    // load capacitance stepper states
    typedef enum logic [1:0] {
        RTCOSC_ST_HOLD,
        RTCOSC_ST_STEP
    } rtcosc_step_state_t;

    typedef logic [3:0] rtcosc_cap_code_t;

endpackage : rtcosc_pkg

// ===== core/rtcosc_cap_if.sv
// link between the register core and the capacitance stepper
`timescale 1ns/1ps
interface rtcosc_cap_if;
    logic restart;
    logic tick;
    logic auto_en;
    rtcosc_pkg::rtcosc_cap_code_t target;
    rtcosc_pkg::rtcosc_cap_code_t applied;
    logic ready;

    modport ctrl (output restart, output tick, output auto_en,
                  output target, input applied, input ready);
    modport step (input restart, input tick, input auto_en,
                  input target, output applied, output ready);
endinterface : rtcosc_cap_if

// ===== core/rtcosc_cap_stepper.sv
// automatic load capacitance stepping toward the programmed code
`timescale 1ns/1ps
`include "rtcosc_map.svh"
module rtcosc_cap_stepper (
    input wire logic ref_clk,
    input wire logic resetn,
    rtcosc_cap_if.step bus
);
    rtcosc_pkg::rtcosc_step_state_t state_ff;
    rtcosc_pkg::rtcosc_cap_code_t code_ff;
    logic [3:0] div_ff;
    logic ready_ff;

    assign bus.applied = code_ff;
    assign bus.ready = ready_ff;

    // ======================================================================
    // stepping machine: one code step per interval of timebase cycles
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= rtcosc_pkg::RTCOSC_ST_HOLD;
            code_ff <= 4'h0;
            div_ff <= 4'h0;
            ready_ff <= 1'b0;
        end else if (bus.restart) begin
            // restart first: the enable is still the old one on this edge,
            // so a write that turns stepping on must not be lost to it
            state_ff <= rtcosc_pkg::RTCOSC_ST_STEP;
            code_ff <= 4'h0;
            div_ff <= 4'h0;
            ready_ff <= 1'b0;
        end else if (!bus.auto_en) begin
            // no stepping: the final code is applied at once
            state_ff <= rtcosc_pkg::RTCOSC_ST_HOLD;
            code_ff <= bus.target;
            ready_ff <= 1'b1;
        end else begin
            case (state_ff)
                rtcosc_pkg::RTCOSC_ST_STEP: begin
                    if (code_ff == bus.target) begin
                        ready_ff <= 1'b1;
                        state_ff <= rtcosc_pkg::RTCOSC_ST_HOLD;
                    end else if (bus.tick) begin
                        div_ff <= div_ff + 4'h1;
                        if (div_ff == `RTCOSC_STEP_OSC_CYCLES) begin
                            code_ff <= code_ff + 4'h1;
                        end
                    end
                end
                rtcosc_pkg::RTCOSC_ST_HOLD: begin
                    // target moved without a restart: climb again
                    if (code_ff != bus.target) begin
                        state_ff <= rtcosc_pkg::RTCOSC_ST_STEP;
                        code_ff <= 4'h0;
                        ready_ff <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= rtcosc_pkg::RTCOSC_ST_HOLD;
                end
            endcase
        end
    end

    // ======================================================================
    // checks
    step_by_one_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (bus.auto_en && !bus.restart && $past(bus.auto_en)
         && code_ff != 4'h0)
        |-> (code_ff == $past(code_ff) || code_ff == $past(code_ff) + 4'h1))
        else $error("applied code jumped by more than one");
    ready_match_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        ready_ff |-> code_ff == bus.target || $changed(bus.target))
        else $error("ready set while code differs from target");
    start_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (bus.auto_en && bus.restart) |=> (code_ff == 4'h0 && !ready_ff))
        else $error("stepping did not start at smallest code");
    reach_ready_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (bus.auto_en && !bus.restart && state_ff ==
         rtcosc_pkg::RTCOSC_ST_STEP && code_ff == bus.target)
        |=> ready_ff)
        else $error("ready not set when target reached");

endmodule : rtcosc_cap_stepper

// ===== sim/rtcosc_xtal_model.sv
// behavioural crystal or cmos clock at the oscillator pins
`timescale 1ns/1ps
module rtcosc_xtal_model (
    input wire logic ref_clk,
    input wire logic run,
    output logic osc_pin_a,
    output logic slow_internal_osc,
    output logic amp_detect
);
    // ======================================================================
    // clock sources
    logic [1:0] div_ff = 2'h0;
    // stopping holds both pins at one level, a stuck oscillator
    always @(posedge ref_clk) begin
        if (run) div_ff <= div_ff + 2'h1;
    end
    assign osc_pin_a = div_ff[1];
    assign slow_internal_osc = div_ff[1];
    assign amp_detect = 1'b1; // amplitude always good
endmodule : rtcosc_xtal_model

// ===== sim/tb_rtc_oscillator_config.sv
// self-checking bench of the oscillator configuration block
`timescale 1ns/1ps
module tb_rtc_oscillator_config;
    logic ref_clk, resetn, psel, penable, pwrite, run, er;
    logic pready, pslverr, irq, osc_pin_a, slow_internal_osc, amp_detect;
    logic osc_power_en, osc_mode_select, bias_double_en, gain_control;
    logic slow_osc_enable, pin_short_ctrl;
    logic [7:0] paddr, rd, t, v;
    logic [31:0] pwdata, prdata;
    logic [3:0] load_cap_code, prev;
    logic [1:0] timer_inc;
    int n_mismatch, compares, i, n;
    rtcosc_xtal_model far (.ref_clk, .run, .osc_pin_a, .slow_internal_osc,
        .amp_detect);
    rtcosc_top #(.BLANK_CYCLES(50), .MISS_CYCLES(20)) dut (.ref_clk, .resetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .irq, .osc_pin_a, .slow_internal_osc, .amp_detect, .osc_power_en,
        .osc_mode_select, .bias_double_en, .gain_control, .slow_osc_enable,
        .pin_short_ctrl, .load_cap_code, .timer_inc);
    // ======================================================================
    // clock, report and bus helpers
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task results;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    task chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk
    task lim(input int ok);
        if (ok == 0) begin
            n_mismatch++;
            $display("unexpected at %0t: wait ran out", $time);
            results();
        end
    endtask : lim
    // sample a little after the edge so registered outputs have landed
    task cyc;
        @(posedge ref_clk);
        #1;
    endtask : cyc
    // apb transfer; no wait-state count assumed, bounded by the timeout
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 50;
        do begin
            @(posedge ref_clk);
            n--;
        end while (pready !== 1'b1 && n > 0);
        lim(int'(pready === 1'b1));
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    // ======================================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, run, resetn} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        n_mismatch = 0;
        compares = 0;
        void'($urandom(75991));
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        run <= 1'b1;
        bus(1'b0, 8'h00, 8'h00);
        chk(rd, 8'h00);
        bus(1'b0, 8'h04, 8'h00);
        chk(rd, 8'h80);
        bus(1'b0, 8'h1C, 8'h00);
        chk({rd[6:0], er}, 8'h01);
        $display("test reset done");
        // every mode and timebase pairing; gain only in crystal mode
        for (i = 0; i < 4; i++) begin
            v = 8'($urandom);
            t = {i[0] & v[7], i[0], v[5], 1'b0, i[1], 3'h0};
            bus(1'b1, 8'h00, t);
            bus(1'b1, 8'h08, {7'h00, v[0]});
            cyc();
            chk({4'h0, gain_control, osc_mode_select, bias_double_en,
                slow_osc_enable}, {4'h0, t[7:5], t[3]});
            chk({7'h00, pin_short_ctrl}, {7'h00, v[0]});
            n = 40;
            while (timer_inc === 2'b00 && n-- > 0) cyc();
            chk({6'h00, timer_inc}, {6'h00, i[1], ~i[1]});
        end
        $display("test modes done");
        // direct code with stepping off, then raise, mask and clear irq
        t = 8'($urandom_range(15));
        bus(1'b1, 8'h04, t);
        cyc();
        cyc();
        chk({4'h0, load_cap_code}, t);
        bus(1'b0, 8'h04, 8'h00);
        chk(rd, t | 8'h40);
        chk({7'h00, irq}, 8'h00);
        bus(1'b1, 8'h14, 8'h02);
        cyc();
        chk({7'h00, irq}, 8'h01);
        bus(1'b1, 8'h10, 8'h02);
        cyc();
        chk({7'h00, irq}, 8'h00);
        $display("test direct code done");
        // stepping climbs one code at a time from zero and then holds
        t = 8'(1 + $urandom_range(14));
        bus(1'b1, 8'h04, 8'h80 | t);
        cyc();
        chk({4'h0, load_cap_code}, 8'h00);
        prev = 4'h0;
        for (n = 3000; load_cap_code !== t[3:0] && n > 0; n--) begin
            cyc();
            if (load_cap_code !== prev) begin
                chk({4'h0, load_cap_code}, {4'h0, prev + 4'h1});
                prev = load_cap_code;
            end
        end
        lim(int'(load_cap_code === t[3:0]));
        repeat (200) cyc();
        chk({7'h00, irq}, 8'h01);
        chk({4'h0, load_cap_code}, t);
        $display("test stepping done");
        // power on blanking, clock valid, then a stuck timebase
        bus(1'b1, 8'h00, 8'h40);
        bus(1'b1, 8'h0C, 8'h03);
        cyc();
        chk({7'h00, osc_power_en}, 8'h01);
        bus(1'b0, 8'h18, 8'h00);
        chk(rd & 8'h0D, 8'h00);
        repeat (60) cyc();
        bus(1'b0, 8'h18, 8'h00);
        chk(rd & 8'h0D, 8'h0C);
        bus(1'b1, 8'h14, 8'h01);
        run <= 1'b0;
        cyc();
        chk({7'h00, irq}, 8'h00);
        for (n = 200; irq !== 1'b1 && n > 0; n--) cyc();
        lim(int'(irq === 1'b1));
        bus(1'b0, 8'h18, 8'h00);
        chk(rd & 8'h01, 8'h01);
        $display("test missing clock done");
        results();
    end
endmodule : tb_rtc_oscillator_config
